// ==== common/srcp_pkg.sv ====
// constants, types and access tables for the serial register command port
// assumes a single 125 MHz clock domain and an axi4-lite control master
package srcp_pkg;

    localparam int BAUD_9600  = 9600;
    localparam int BAUD_19200 = 19200;
    localparam int BAUD_38400 = 38400;
    localparam int BAUD_57600 = 57600;

    localparam logic [7:0] CH_CR    = 8'h0d;
    localparam logic [7:0] CH_COMMA = 8'h2c;
    localparam logic [7:0] CH_R     = 8'h52;
    localparam logic [7:0] CH_Q     = 8'h51;
    localparam logic [7:0] CH_0     = 8'h30;
    localparam logic [7:0] CH_9     = 8'h39;
    localparam logic [7:0] CH_A     = 8'h41;
    localparam logic [7:0] CH_F     = 8'h46;
    localparam logic [7:0] CH_ACK   = 8'h06;
    localparam logic [7:0] CH_NAK   = 8'h15;
    localparam logic [7:0] HEX_A_OFS = 8'h37;

    localparam logic [1:0] ADDR_MAX_DIGITS = 2'h2;
    localparam logic [3:0] DATA_MAX_DIGITS = 4'h8;
    localparam logic [3:0] FRAME_BITS      = 4'h9;

    localparam logic [7:0] REG_RAND_EXPOSURE_TRIGGER_INPUT = 8'h92;
    localparam logic [7:0] REG_EXPOSURE_TRIGGER_INPUT_POL  = 8'h93;

    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_CMD_CNT = 8'h08;
    localparam logic [7:0]  OFS_NAK_CNT = 8'h0c;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       base_cfg;
        logic [1:0] baud_sel;
        logic [2:0] bank;
    } srcp_cfg_s;

    typedef enum logic [4:0] {
        ST_ADDR = 5'h01,
        ST_DATA = 5'h02,
        ST_RQ_R = 5'h04,
        ST_RQ_Q = 5'h08,
        ST_SEND = 5'h10
    } srcp_state_e;

    function automatic logic srcp_is_rw(input logic [7:0] a);
        case (a)
            8'h6e, 8'h70, 8'h76, 8'h86, 8'h87, 8'h8b, 8'h90, 8'h91, 8'h92,
            8'h93, 8'h94, 8'ha0, 8'ha4, 8'hc1, 8'hc2, 8'hc4, 8'hc6, 8'hc8,
            8'hcb, 8'hcc, 8'hd8, 8'hda, 8'hdc, 8'he1: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : srcp_is_rw

    function automatic logic srcp_readable(input logic [7:0] a);
        return (a <= 8'h67) || (a == 8'h69) || (a == 8'h6a) ||
               (a == 8'h6c) || srcp_is_rw(a);
    endfunction : srcp_readable

    function automatic logic srcp_writable(input logic [7:0] a);
        return (a == 8'h6d) || (a == 8'h6f) || (a == 8'hc0) ||
               (a == 8'hdb) || srcp_is_rw(a);
    endfunction : srcp_writable

endpackage : srcp_pkg

// ==== design/srcp_command_port.sv ====
// ascii register command interpreter on the camera serial control link
// assumes pins and switches are asynchronous; axi4-lite master on aclk
`timescale 1ns/1ns
`default_nettype none

module srcp_command_port #(
    parameter int CLK_HZ = 125_000_000
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // serial link
    input  wire logic        serial_rx,
    output logic             serial_tx,
    // back-panel switches
    input  wire logic        output_config_switch,
    input  wire logic        baud_select_switch_low,
    input  wire logic        baud_select_switch_high,
    input  wire logic        bank_select_bit0,
    input  wire logic        bank_select_bit1,
    input  wire logic        bank_select_bit2,
    // trigger
    input  wire logic        exposure_trigger_input,
    // captured start-up settings
    output logic             base_config_sel,
    output logic [2:0]       startup_bank,
    output logic             cfg_valid
);

    localparam logic [15:0] DIV_9600  = 16'(CLK_HZ / srcp_pkg::BAUD_9600);
    localparam logic [15:0] DIV_19200 = 16'(CLK_HZ / srcp_pkg::BAUD_19200);
    localparam logic [15:0] DIV_38400 = 16'(CLK_HZ / srcp_pkg::BAUD_38400);
    localparam logic [15:0] DIV_57600 = 16'(CLK_HZ / srcp_pkg::BAUD_57600);
    localparam int NPIN = 8;

    // pin synchronisers, change accepted when stages two and three agree
    logic [NPIN-1:0] pins;
    logic [NPIN-1:0] sync1_r;
    logic [NPIN-1:0] sync2_r;
    logic [NPIN-1:0] sync3_r;
    logic [NPIN-1:0] filt_r;

    assign pins = {exposure_trigger_input, serial_rx, bank_select_bit2,
                   bank_select_bit1, bank_select_bit0, baud_select_switch_high,
                   baud_select_switch_low, output_config_switch};

    always_ff @(posedge aclk)
    begin
        sync1_r <= pins;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_filt
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    filt_r[gi] <= (gi == 6);
                else if (sync2_r[gi] == sync3_r[gi])
                    filt_r[gi] <= sync3_r[gi];
            end
        end
    endgenerate

    wire rx_pin   = filt_r[6];
    wire exposure_trigger_input_pin = filt_r[7];

    // one-time switch capture after reset release
    srcp_pkg::srcp_cfg_s cfg_r;
    logic                cfg_done_r;
    logic [2:0]          settle_r;
    logic [15:0]         baud_div_r;
    logic [15:0]         div_sel;
    srcp_pkg::srcp_cfg_s cfg_pins;

    assign cfg_pins = '{base_cfg: filt_r[0],
                        baud_sel: filt_r[2:1],
                        bank:     filt_r[5:3]};
    assign div_sel = (cfg_pins.baud_sel == 2'h3) ? DIV_57600 :
                     (cfg_pins.baud_sel == 2'h2) ? DIV_38400 :
                     (cfg_pins.baud_sel == 2'h1) ? DIV_19200 :
                                                   DIV_9600;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_r      <= '0;
            cfg_done_r <= 1'b0;
            settle_r   <= 3'h0;
            baud_div_r <= DIV_9600;
        end
        else if (!cfg_done_r)
        begin
            settle_r <= settle_r + 3'h1;
            if (settle_r == 3'h7)
            begin
                cfg_r      <= cfg_pins;
                baud_div_r <= div_sel;
                cfg_done_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        base_config_sel <= cfg_r.base_cfg;
        startup_bank    <= cfg_r.bank;
        cfg_valid       <= cfg_done_r;
    end

    // receiver: 8 data bits, 1 stop, no parity
    logic        rx_busy_r;
    logic [15:0] rx_cnt_r;
    logic [3:0]  rx_bit_r;
    logic [7:0]  rx_shift_r;
    logic [7:0]  rx_byte_r;
    logic        rx_stb_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !cfg_done_r)
        begin
            rx_busy_r <= 1'b0;
            rx_cnt_r  <= 16'h0;
            rx_bit_r  <= 4'h0;
            rx_stb_r  <= 1'b0;
        end
        else
        begin
            rx_stb_r <= 1'b0;
            if (!rx_busy_r)
            begin
                if (!rx_pin)
                begin
                    rx_busy_r <= 1'b1;
                    rx_cnt_r  <= baud_div_r >> 1;
                    rx_bit_r  <= 4'h0;
                end
            end
            else if (rx_cnt_r != 16'h0)
                rx_cnt_r <= rx_cnt_r - 16'h1;
            else
            begin
                rx_cnt_r <= baud_div_r - 16'h1;
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == 4'h0 && rx_pin)
                    rx_busy_r <= 1'b0;
                else if (rx_bit_r == srcp_pkg::FRAME_BITS)
                begin
                    rx_busy_r <= 1'b0;
                    rx_stb_r  <= rx_pin;
                    rx_byte_r <= rx_shift_r;
                end
                else if (rx_bit_r != 4'h0)
                    rx_shift_r <= {rx_pin, rx_shift_r[7:1]};
            end
        end
    end

    // register map, reachable only from the serial parser
    logic [31:0] map_r [256];
    logic [31:0] ctrl_r;
    logic [15:0] cmd_cnt_r;
    logic [15:0] nak_cnt_r;

    wire port_en   = ctrl_r[0];
    wire exposure_trigger_input_lvl  = exposure_trigger_input_pin == map_r[srcp_pkg::REG_EXPOSURE_TRIGGER_INPUT_POL][0];
    wire expo_busy = (map_r[srcp_pkg::REG_RAND_EXPOSURE_TRIGGER_INPUT] != 32'h0) && exposure_trigger_input_lvl;

    // parser
    srcp_pkg::srcp_state_e st_r;
    logic [7:0]  addr_r;
    logic [1:0]  alen_r;
    logic [31:0] data_r;
    logic [3:0]  dlen_r;
    logic        err_r;
    logic [31:0] rval_r;
    logic [1:0]  rkind_r;
    logic [3:0]  rlen_r;
    logic [3:0]  ridx_r;

    wire       take_ch = rx_stb_r && port_en && !expo_busy &&
                         (st_r != srcp_pkg::ST_SEND);
    wire [7:0] ch      = rx_byte_r;
    wire       is_dig  = ch >= srcp_pkg::CH_0 && ch <= srcp_pkg::CH_9;
    wire       is_uhex = ch >= srcp_pkg::CH_A && ch <= srcp_pkg::CH_F;
    wire       is_hex  = is_dig || is_uhex;
    wire [7:0] nib8    = is_dig ? ch - srcp_pkg::CH_0 :
                                  ch - srcp_pkg::HEX_A_OFS;
    wire [3:0] nib     = nib8[3:0];
    wire       is_cr   = ch == srcp_pkg::CH_CR;
    wire       is_read = st_r == srcp_pkg::ST_RQ_Q;
    wire       bad_end = err_r || alen_r == 2'h0 ||
                         (is_read ? !srcp_pkg::srcp_readable(addr_r) :
                          (st_r != srcp_pkg::ST_DATA || dlen_r == 4'h0 ||
                           !srcp_pkg::srcp_writable(addr_r)));
    wire       do_wr   = take_ch && is_cr && !bad_end && !is_read;
    wire [31:0] rd_word = map_r[addr_r];

    logic [3:0] rd_digits;
    always_comb
    begin
        rd_digits = 4'h1;
        for (int i = 1; i < 8; i++)
        begin
            if (rd_word[4*i +: 4] != 4'h0)
                rd_digits = 4'(i + 1);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < 256; i++)
                map_r[i] <= 32'h0;
        end
        else if (do_wr)
            map_r[addr_r] <= data_r;
    end

    // answer characters
    logic       tx_go_r;
    logic       tx_busy_r;
    logic [7:0] tx_ch;
    wire  [3:0] dig_pos = rlen_r - 4'h2 - ridx_r;
    wire  [3:0] dig_nib = rval_r[{dig_pos[2:0], 2'b00} +: 4];
    wire  [7:0] dig_ch  = (dig_nib > 4'h9) ?
                          {4'h0, dig_nib} + srcp_pkg::HEX_A_OFS :
                          {4'h0, dig_nib} + srcp_pkg::CH_0;
    wire        last_ch = ridx_r == rlen_r - 4'h1;

    assign tx_ch = last_ch        ? srcp_pkg::CH_CR  :
                   rkind_r == 2'h0 ? srcp_pkg::CH_ACK :
                   rkind_r == 2'h1 ? srcp_pkg::CH_NAK : dig_ch;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r      <= srcp_pkg::ST_ADDR;
            alen_r    <= 2'h0;
            dlen_r    <= 4'h0;
            err_r     <= 1'b0;
            rkind_r   <= 2'h0;
            rlen_r    <= 4'h0;
            ridx_r    <= 4'h0;
            tx_go_r   <= 1'b0;
            cmd_cnt_r <= 16'h0;
            nak_cnt_r <= 16'h0;
            addr_r    <= 8'h0;
            data_r    <= 32'h0;
        end
        else
        begin
            tx_go_r <= 1'b0;
            if (take_ch && is_cr)
            begin
                st_r      <= srcp_pkg::ST_SEND;
                ridx_r    <= 4'h0;
                rval_r    <= rd_word;
                cmd_cnt_r <= cmd_cnt_r + 16'h1;
                if (bad_end)
                begin
                    rkind_r   <= 2'h1;
                    rlen_r    <= 4'h2;
                    nak_cnt_r <= nak_cnt_r + 16'h1;
                end
                else if (is_read)
                begin
                    rkind_r <= 2'h2;
                    rlen_r  <= rd_digits + 4'h1;
                end
                else
                begin
                    rkind_r <= 2'h0;
                    rlen_r  <= 4'h2;
                end
            end
            else if (take_ch)
            begin
                case (st_r)
                    srcp_pkg::ST_ADDR:
                        if (ch == srcp_pkg::CH_COMMA)
                            st_r <= srcp_pkg::ST_DATA;
                        else if (!is_hex ||
                                 alen_r == srcp_pkg::ADDR_MAX_DIGITS)
                            err_r <= 1'b1;
                        else
                        begin
                            addr_r <= {addr_r[3:0], nib};
                            alen_r <= alen_r + 2'h1;
                        end
                    srcp_pkg::ST_DATA:
                        if (ch == srcp_pkg::CH_R && dlen_r == 4'h0)
                            st_r <= srcp_pkg::ST_RQ_R;
                        else if (!is_hex ||
                                 dlen_r == srcp_pkg::DATA_MAX_DIGITS)
                            err_r <= 1'b1;
                        else
                        begin
                            data_r <= {data_r[27:0], nib};
                            dlen_r <= dlen_r + 4'h1;
                        end
                    srcp_pkg::ST_RQ_R:
                        if (ch == srcp_pkg::CH_Q)
                            st_r <= srcp_pkg::ST_RQ_Q;
                        else
                            err_r <= 1'b1;
                    default:
                        err_r <= 1'b1;
                endcase
            end
            else if (st_r == srcp_pkg::ST_SEND && !tx_busy_r && !tx_go_r)
            begin
                if (ridx_r == rlen_r)
                begin
                    st_r   <= srcp_pkg::ST_ADDR;
                    alen_r <= 2'h0;
                    dlen_r <= 4'h0;
                    addr_r <= 8'h0;
                    data_r <= 32'h0;
                    err_r  <= 1'b0;
                end
                else
                    tx_go_r <= 1'b1;
            end
            if (tx_go_r)
                ridx_r <= ridx_r + 4'h1;
        end
    end

    // transmitter
    logic [15:0] tx_cnt_r;
    logic [3:0]  tx_bit_r;
    logic [9:0]  tx_shift_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_busy_r  <= 1'b0;
            tx_cnt_r   <= 16'h0;
            tx_bit_r   <= 4'h0;
            tx_shift_r <= 10'h3ff;
            serial_tx  <= 1'b1;
        end
        else if (tx_go_r)
        begin
            tx_busy_r  <= 1'b1;
            tx_shift_r <= {1'b1, tx_ch, 1'b0};
            tx_cnt_r   <= 16'h0;
            tx_bit_r   <= 4'h0;
        end
        else if (tx_busy_r)
        begin
            if (tx_cnt_r != 16'h0)
                tx_cnt_r <= tx_cnt_r - 16'h1;
            else if (tx_bit_r == srcp_pkg::FRAME_BITS + 4'h1)
                tx_busy_r <= 1'b0;
            else
            begin
                serial_tx  <= tx_shift_r[0];
                tx_shift_r <= {1'b1, tx_shift_r[9:1]};
                tx_cnt_r   <= baud_div_r - 16'h1;
                tx_bit_r   <= tx_bit_r + 4'h1;
            end
        end
    end

    // axi4-lite slave: control, status and command/nak counters only
    wire wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire rd_hs = s_axi_arvalid && s_axi_arready;
    wire wr_ok = s_axi_awaddr == srcp_pkg::OFS_CTRL;
    wire [31:0] status_w = {16'h0, 3'h0, st_r, expo_busy, cfg_done_r,
                            cfg_r.base_cfg, cfg_r.baud_sel, cfg_r.bank};
    wire        rd_ok    = s_axi_araddr == srcp_pkg::OFS_CTRL ||
                           s_axi_araddr == srcp_pkg::OFS_STATUS ||
                           s_axi_araddr == srcp_pkg::OFS_CMD_CNT ||
                           s_axi_araddr == srcp_pkg::OFS_NAK_CNT;
    wire [31:0] rd_mux   =
        (s_axi_araddr == srcp_pkg::OFS_CTRL)    ? ctrl_r :
        (s_axi_araddr == srcp_pkg::OFS_STATUS)  ? status_w :
        (s_axi_araddr == srcp_pkg::OFS_CMD_CNT) ? {16'h0, cmd_cnt_r} :
        (s_axi_araddr == srcp_pkg::OFS_NAK_CNT) ? {16'h0, nak_cnt_r} :
                                                  32'h0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= srcp_pkg::RESP_OKAY;
            ctrl_r        <= srcp_pkg::CTRL_RESET;
        end
        else
        begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid &&
                             !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid && s_axi_wvalid &&
                             !s_axi_awready && !s_axi_bvalid;
            if (wr_hs)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? srcp_pkg::RESP_OKAY :
                                        srcp_pkg::RESP_SLVERR;
                if (wr_ok && s_axi_wstrb[0])
                    ctrl_r[7:0] <= s_axi_wdata[7:0];
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= srcp_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (rd_hs)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_ok ? srcp_pkg::RESP_OKAY :
                                        srcp_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule : srcp_command_port

`default_nettype wire

// ==== design/placeholder_none.sv ====
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ==== sim/srcp_asserts.sv ====
// assertion checker on the command port's top-level ports
// bound into every srcp_command_port instance
`timescale 1ns/1ns
`default_nettype none
module srcp_asserts (
    input wire logic       aclk, aresetn,
    input wire logic [7:0] s_axi_awaddr, s_axi_araddr,
    input wire logic       s_axi_awvalid, s_axi_awready, s_axi_bvalid,
    input wire logic       s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic [1:0] s_axi_bresp, s_axi_rresp,
    input wire logic       serial_tx, output_config_switch, base_config_sel,
    input wire logic       bank_select_bit0, bank_select_bit1,
    input wire logic       bank_select_bit2, cfg_valid,
    input wire logic [2:0] startup_bank
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_idle; !cfg_valid |-> serial_tx; endproperty
    a_idle: assert property (p_idle) else $error("tx busy");
    property p_start; $fell(serial_tx) |-> !serial_tx [*8]; endproperty
    a_start: assert property (p_start) else $error("short start");
    property p_bank; $rose(cfg_valid) |-> startup_bank ==
        {bank_select_bit2, bank_select_bit1, bank_select_bit0}; endproperty
    a_bank: assert property (p_bank) else $error("bank");
    property p_base; $rose(cfg_valid) |->
        base_config_sel == output_config_switch; endproperty
    a_base: assert property (p_base) else $error("base");
    property p_hold; cfg_valid |=>
        $stable(startup_bank) && $stable(base_config_sel); endproperty
    a_hold: assert property (p_hold) else $error("moved");
    property p_werr; s_axi_awvalid && s_axi_awready &&
        s_axi_awaddr != srcp_pkg::OFS_CTRL |=> s_axi_bvalid &&
        s_axi_bresp == srcp_pkg::RESP_SLVERR; endproperty
    a_werr: assert property (p_werr) else $error("wresp");
    property p_rerr; s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > srcp_pkg::OFS_NAK_CNT |=> s_axi_rvalid &&
        s_axi_rresp == srcp_pkg::RESP_SLVERR; endproperty
    a_rerr: assert property (p_rerr) else $error("rresp");
    property p_rans; $rose(s_axi_rvalid) |-> $past(s_axi_arready); endproperty
    a_rans: assert property (p_rans) else $error("rvalid");
endmodule : srcp_asserts
bind srcp_command_port srcp_asserts u_srcp_asserts (.*);
`default_nettype wire

// ==== sim/srcp_host.sv ====
// serial host partner: sends command bytes, collects answer bytes
// bit time is div cycles of the bench clock
`timescale 1ns/1ns
`default_nettype none
module srcp_host (
    input  wire logic aclk,
    input  wire logic serial_tx,
    output var logic  serial_rx
);
    int         div = 60;
    logic [7:0] rx_q[$];
    initial serial_rx = 1'b1;
    task automatic send_byte(input logic [7:0] c);
        for (int i = 0; i < 10; i++)
        begin
            serial_rx <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : c[i - 1];
            repeat (div) @(posedge aclk);
        end
    endtask : send_byte
    always
    begin : rx_proc
        logic [8:0] b;
        @(negedge serial_tx);
        repeat (div / 2) @(posedge aclk);
        for (int i = 0; i < 9; i++)
        begin
            repeat (div) @(posedge aclk);
            b[i] = serial_tx;
        end
        if (b[8] === 1'b1) rx_q.push_back(b[7:0]);
    end
endmodule : srcp_host
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the serial register command port
// axi4-lite and switches from here; srcp_host is the serial host
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, exposure_trigger_input = 1'b0;
    logic        output_config_switch = 1'b0, bank_select_bit0 = 1'b0;
    logic        baud_select_switch_low = 1'b0, bank_select_bit1 = 1'b0;
    logic        baud_select_switch_high = 1'b0, bank_select_bit2 = 1'b0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, serial_rx;
    wire logic   s_axi_arready, s_axi_rvalid, serial_tx, cfg_valid;
    wire logic   base_config_sel;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [2:0]  startup_bank;
    wire logic [31:0] s_axi_rdata;
    int    n_errors = 0, check_count = 0, seed = 32'h7b9a;
    string ack = "\006\r", nak = "\025\r";
    string bad[4] = '{"76,3a\r", "176,1\r", "76,123456789\r", "6D,RQ\r"};
    int    rates[4] = '{srcp_pkg::BAUD_9600, srcp_pkg::BAUD_19200,
                        srcp_pkg::BAUD_38400, srcp_pkg::BAUD_57600};

    srcp_command_port #(.CLK_HZ(576000)) u_srcp_command_port (.*);
    srcp_host u_srcp_host (.*);

    initial
    begin
        forever #4 aclk = ~aclk;
    end

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic axi(input logic w, input logic [7:0] a,
                       inout logic [31:0] d, output logic [1:0] r);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
        {s_axi_bready, s_axi_rready} <= {w, !w};
        do @(posedge aclk);
        while ((w ? s_axi_awready & s_axi_wready : s_axi_arready) !== 1'b1);
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
        do @(posedge aclk);
        while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
        {s_axi_bready, s_axi_rready} <= 2'h0;
        {d, r} = w ? {d, s_axi_bresp} : {s_axi_rdata, s_axi_rresp};
    endtask : axi

    function automatic string hx(input logic [31:0] v);
        string s = "";
        do
        begin
            s = $sformatf("%c%s", v[3:0] + (v[3:0] < 4'ha ? 8'h30 : 8'h37),
                          s);
            v = v >> 4;
        end
        while (v != 32'h0);
        return s;
    endfunction : hx

    task automatic cmd(input string s, input string e);
        for (int i = 0; i < s.len(); i++)
            u_srcp_host.send_byte(s[i]);
        repeat ((e.len() + 2) * 12 * u_srcp_host.div)
            if (u_srcp_host.rx_q.size() < e.len()) @(posedge aclk);
        repeat (15 * u_srcp_host.div) @(posedge aclk);
        chk(u_srcp_host.rx_q.size(), e.len());
        foreach (u_srcp_host.rx_q[i])
            if (i < e.len()) chk(u_srcp_host.rx_q[i], e[i]);
        u_srcp_host.rx_q.delete();
    endtask : cmd

    task automatic summarize();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (90000) @(posedge aclk);
        n_errors++;
        summarize();
    end

    initial
    begin : main
        logic [31:0] d, st;
        logic [1:0]  r;
        logic [3:0]  sw;
        for (int b = 0; b < 4; b++)
        begin
            sw = 4'($random(seed));
            @(posedge aclk);
            aresetn <= 1'b0;
            {bank_select_bit2, bank_select_bit1, bank_select_bit0} <= sw[2:0];
            output_config_switch <= sw[3];
            baud_select_switch_low <= b[0];
            baud_select_switch_high <= b[1];
            u_srcp_host.div = 576000 / rates[b];
            repeat (8) @(posedge aclk);
            aresetn <= 1'b1;
            repeat (40) if (cfg_valid !== 1'b1) @(posedge aclk);
            chk({startup_bank, base_config_sel}, {sw[2:0], sw[3]});
            {bank_select_bit2, bank_select_bit1, bank_select_bit0} <= ~sw[2:0];
            output_config_switch <= ~sw[3];
            baud_select_switch_low <= ~b[0];
            axi(1'b0, srcp_pkg::OFS_STATUS, st, r);
            chk(st[6:0], {1'b1, sw[3], b[1:0], sw[2:0]});
            d = (b == 3) ? 32'h10 : 32'($random(seed)) >> (8 * b);
            cmd({"76,", hx(d), "\r"}, ack);
            cmd(bad[b], nak);
            cmd("76,RQ\r", {hx(d), "\r"});
            if (b == 0)
            begin
                axi(1'b0, srcp_pkg::OFS_CTRL, st, r);
                chk(st, srcp_pkg::CTRL_RESET);
                axi(1'b0, 8'h10, st, r);
                chk({st, r}, {32'h0, srcp_pkg::RESP_SLVERR});
                axi(1'b1, srcp_pkg::OFS_STATUS, st, r);
                chk(r, srcp_pkg::RESP_SLVERR);
                axi(1'b0, srcp_pkg::OFS_CMD_CNT, st, r);
                chk(st, 32'h3);
                axi(1'b0, srcp_pkg::OFS_NAK_CNT, st, r);
                chk(st, 32'h1);
                st = 32'h0;
                axi(1'b1, srcp_pkg::OFS_CTRL, st, r);
                chk(r, srcp_pkg::RESP_OKAY);
                cmd("76,RQ\r", "");
                st = srcp_pkg::CTRL_RESET;
                axi(1'b1, srcp_pkg::OFS_CTRL, st, r);
            end
            if (b == 3)
            begin
                cmd("C2,40\r", ack);
                cmd("C4,30\r", ack);
                cmd("C0,1\r", ack);
                cmd("92,1\r", ack);
                cmd("76,RQ\r", "");
                exposure_trigger_input <= 1'b1;
                cmd("76,RQ\r", "10\r");
            end
        end
        summarize();
    end
endmodule : tb_top
`default_nettype wire
